/* rtl/mhrw_pkg.sv */
// Constants and types for the module health and reset word logic
package mhrw_pkg;
    localparam int WORD_W = 16;
    localparam int CODE_W = 8;
    // Bit 1 of a word is its msb, so position p sits at index WORD_W - p
    localparam int POS_FAIL = 15;
    localparam int POS_SER = 14;
    localparam int POS_NET = 13;
    localparam int POS_DIAG = 12;
    localparam int POS_CFG = 11;
    localparam int POS_ALT = 10;
    localparam int POS_RSV7 = 9;
    localparam int POS_RSV8 = 8;
    localparam int POS_MODRST = 15;
    // Abort triggers sit at positions 4, 8, 12, 16 of the command control word
    localparam logic [WORD_W-1:0] ABORT_MASK = 16'h1111;
    localparam logic [WORD_W-1:0] HEALTH_RESET = 16'h6000;
    localparam int CLK_HZ = 25_000_000;
    localparam int RETRY_WAIT_MS = 1000;
    localparam int RETRY_WAIT_CYC = CLK_HZ / 1000 * RETRY_WAIT_MS;
    localparam int SHORT_WAIT_US = 100;
    localparam int SHORT_WAIT_CYC = CLK_HZ / 1_000_000 * SHORT_WAIT_US;
    localparam int TICK_US = 1000;
    localparam int TICK_CYC = CLK_HZ / 1_000_000 * TICK_US;
    localparam int STARTUP_CYC = 4;
    localparam int CNT_W = 32;
    typedef enum logic [1:0] {
        MHRW_START = 2'b00,
        MHRW_RUN = 2'b01,
        MHRW_WAIT = 2'b11
    } mhrw_state_e;
endpackage : mhrw_pkg

/* rtl/mhrw_counter.sv */
// Terminal-count timer reused for the heartbeat tick and the reset waits
`timescale 1ns/100ps
`default_nettype none
module mhrw_counter #(
    parameter int W = 32
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Control
    input wire logic run,
    input wire logic [W-1:0] limit,
    // Status
    output logic done
);
    logic [W-1:0] cnt_q;
    always_ff @(posedge clk) begin
        if (rst || !run) begin
            cnt_q <= '0;
        end else if (cnt_q >= limit - W'(1)) begin
            cnt_q <= '0;
        end else begin
            cnt_q <= cnt_q + W'(1);
        end
    end
    assign done = run && (cnt_q >= limit - W'(1));
endmodule : mhrw_counter
`default_nettype wire

/* rtl/mhrw_core.sv */
// Module health word and control word reset logic
//
// Overview of operation
// - Severe fault: flag fail, wait, reset
// - Retry reset while fault persists
// - Serial pending flag until ports configured
// - Network pending flag until parameters loaded
// - Selftest fault sets fail, short reset
// - Setup fault flagged at startup checks
// - Alternate port selected without link pulse
// - Positions 7 and 8 read zero
// - Low byte: heartbeat, or fault code
// - Reset needs bit 1 plus aborts
// - Reset reruns diagnostics and startup
`timescale 1ns/100ps
`default_nettype none
module mhrw_core
    import mhrw_pkg::*;
#(
    parameter int RETRY_CYC = mhrw_pkg::RETRY_WAIT_CYC,
    parameter int SHORT_CYC = mhrw_pkg::SHORT_WAIT_CYC,
    parameter int HB_CYC = mhrw_pkg::TICK_CYC
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic sys_rst,
    // Controller words
    input wire logic [mhrw_pkg::WORD_W-1:0] commandOutputWord,
    input wire logic [mhrw_pkg::WORD_W-1:0] commandControlWord,
    output logic [mhrw_pkg::WORD_W-1:0] healthInputWord,
    // Diagnostic and configuration inputs
    input wire logic severeFault,
    input wire logic ramRomFault,
    input wire logic [mhrw_pkg::CODE_W-1:0] faultCode,
    input wire logic faultCodeValid,
    input wire logic switchesInvalid,
    input wire logic nvStoreInvalid,
    input wire logic serialPortsDone,
    input wire logic networkLoaded,
    input wire logic linkPulseSeen,
    // Module processor reset
    output logic moduleReset
);
    import mhrw_pkg::*;

    mhrw_state_e state_q;
    logic [CNT_W-1:0] startCnt_q;
    logic waitShort_q;
    logic rstArmed_q;
    logic failFlag_q, serPend_q, netPend_q, diagFlag_q, cfgFlag_q, altPort_q;
    logic [CODE_W-1:0] field_q;
    logic [CODE_W-1:0] beat_q;
    logic codeHeld_q;
    logic ctrlReq;
    logic hbDone, waitDone;
    logic [CNT_W-1:0] waitLimit;

    // Reset bit of the command output word plus the abort trigger of every command group
    assign ctrlReq = commandOutputWord[POS_MODRST]
        && ((commandControlWord & ABORT_MASK) == ABORT_MASK);
    assign waitLimit = waitShort_q ? CNT_W'(SHORT_CYC) : CNT_W'(RETRY_CYC);

    mhrw_counter #(.W(CNT_W)) u_hb (
        .clk(core_clk),
        .rst(sys_rst),
        .run(state_q == MHRW_RUN),
        .limit(CNT_W'(HB_CYC)),
        .done(hbDone)
    );
    mhrw_counter #(.W(CNT_W)) u_wait (
        .clk(core_clk),
        .rst(sys_rst),
        .run(state_q == MHRW_WAIT),
        .limit(waitLimit),
        .done(waitDone)
    );

    // Sequencer: startup checks, normal run, wait before internal reset
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            state_q <= MHRW_START;
            startCnt_q <= '0;
            waitShort_q <= 1'b0;
        end else begin
            unique case (state_q)
                MHRW_START: begin
                    startCnt_q <= startCnt_q + CNT_W'(1);
                    if (startCnt_q >= CNT_W'(STARTUP_CYC - 1)) begin
                        state_q <= MHRW_RUN;
                    end
                end
                MHRW_RUN: begin
                    startCnt_q <= '0;
                    if (ctrlReq && rstArmed_q) begin
                        state_q <= MHRW_START;
                    end else if (ramRomFault) begin
                        waitShort_q <= 1'b1;
                        state_q <= MHRW_WAIT;
                    end else if (severeFault) begin
                        waitShort_q <= 1'b0;
                        state_q <= MHRW_WAIT;
                    end
                end
                MHRW_WAIT: begin
                    // Internal reset reruns startup, retrying forever if fault stays
                    if (waitDone) begin
                        state_q <= MHRW_START;
                    end
                end
                default: state_q <= MHRW_START;
            endcase
        end
    end

    // Reset request is consumed once until released
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            rstArmed_q <= 1'b0;
        end else if (!ctrlReq) begin
            rstArmed_q <= 1'b1;
        end else if (state_q == MHRW_RUN) begin
            rstArmed_q <= 1'b0;
        end
    end

    // Processor reset held through the startup phase
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            moduleReset <= 1'b1;
        end else begin
            moduleReset <= (state_q == MHRW_START) && (startCnt_q < CNT_W'(STARTUP_CYC - 1));
        end
    end

    // Health flags
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            failFlag_q <= 1'b0;
            diagFlag_q <= 1'b0;
            cfgFlag_q <= 1'b0;
            serPend_q <= 1'b1;
            netPend_q <= 1'b1;
            altPort_q <= 1'b0;
        end else if (state_q == MHRW_START) begin
            // Pending flags rise again on every restart
            serPend_q <= 1'b1;
            netPend_q <= 1'b1;
            cfgFlag_q <= switchesInvalid || nvStoreInvalid;
            failFlag_q <= severeFault || ramRomFault;
            diagFlag_q <= ramRomFault;
            altPort_q <= 1'b0;
        end else begin
            if (severeFault || ramRomFault) begin
                failFlag_q <= 1'b1;
            end
            if (ramRomFault) begin
                diagFlag_q <= 1'b1;
            end
            if (serialPortsDone) begin
                serPend_q <= 1'b0;
            end
            if (networkLoaded) begin
                netPend_q <= 1'b0;
            end
            altPort_q <= !linkPulseSeen;
        end
    end

    // Heartbeat counts only while running, so a stall freezes the field
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            beat_q <= '0;
        end else if (hbDone) begin
            beat_q <= beat_q + CODE_W'(1);
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            codeHeld_q <= 1'b0;
            field_q <= '0;
        end else if (faultCodeValid) begin
            codeHeld_q <= 1'b1;
            field_q <= faultCode;
        end else if (state_q == MHRW_START) begin
            codeHeld_q <= 1'b0;
        end else if (!codeHeld_q) begin
            field_q <= beat_q;
        end
    end

    // Word assembly; position 1 is the msb
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            healthInputWord <= HEALTH_RESET;
        end else begin
            healthInputWord <= '0;
            healthInputWord[POS_FAIL] <= failFlag_q;
            healthInputWord[POS_SER] <= serPend_q;
            healthInputWord[POS_NET] <= netPend_q;
            healthInputWord[POS_DIAG] <= diagFlag_q;
            healthInputWord[POS_CFG] <= cfgFlag_q;
            healthInputWord[POS_ALT] <= altPort_q;
            healthInputWord[POS_RSV7] <= 1'b0;
            healthInputWord[POS_RSV8] <= 1'b0;
            healthInputWord[CODE_W-1:0] <= field_q;
        end
    end

    property p_fail_on_fault;
        @(posedge core_clk) disable iff (sys_rst)
            (state_q == MHRW_RUN && severeFault) |-> ##2 healthInputWord[POS_FAIL];
    endproperty
    a_fail_on_fault: assert property (p_fail_on_fault) else $error("fail flag missing");

    property p_wait_restart;
        @(posedge core_clk) disable iff (sys_rst)
            (state_q == MHRW_WAIT && waitDone) |=> state_q == MHRW_START;
    endproperty
    a_wait_restart: assert property (p_wait_restart) else $error("no restart after wait");

    property p_diag_sets_fail;
        @(posedge core_clk) disable iff (sys_rst)
            healthInputWord[POS_DIAG] |-> healthInputWord[POS_FAIL];
    endproperty
    a_diag_sets_fail: assert property (p_diag_sets_fail) else $error("diag without fail");

    property p_ser_clear;
        @(posedge core_clk) disable iff (sys_rst)
            (state_q == MHRW_RUN && serialPortsDone) ##1 (state_q == MHRW_RUN)
                |=> !healthInputWord[POS_SER];
    endproperty
    a_ser_clear: assert property (p_ser_clear) else $error("serial pending stuck");

    property p_reserved_zero;
        @(posedge core_clk) disable iff (sys_rst)
            !healthInputWord[POS_RSV7] && !healthInputWord[POS_RSV8];
    endproperty
    a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bit set");

    property p_alt_port;
        @(posedge core_clk) disable iff (sys_rst)
            (state_q == MHRW_RUN && !linkPulseSeen) ##1 (state_q == MHRW_RUN)
                |=> healthInputWord[POS_ALT];
    endproperty
    a_alt_port: assert property (p_alt_port) else $error("alternate port not shown");

    sequence s_req_taken;
        state_q == MHRW_RUN && ctrlReq && rstArmed_q;
    endsequence
    property p_ctrl_reset;
        @(posedge core_clk) disable iff (sys_rst)
            s_req_taken |=> ##1 moduleReset;
    endproperty
    a_ctrl_reset: assert property (p_ctrl_reset) else $error("control reset ignored");

    property p_no_partial_reset;
        @(posedge core_clk) disable iff (sys_rst)
            (state_q == MHRW_RUN && !ctrlReq && !severeFault && !ramRomFault)
                |=> state_q != MHRW_START;
    endproperty
    a_no_partial_reset: assert property (p_no_partial_reset) else $error("spurious reset");

    property p_once;
        @(posedge core_clk) disable iff (sys_rst)
            s_req_taken ##1 ctrlReq[*8] |-> !rstArmed_q;
    endproperty
    a_once: assert property (p_once) else $error("reset rearmed while held");
endmodule : mhrw_core
`default_nettype wire

/* bench/mhrw_plc_model.sv */
// Controller model: drives the command word and watches the heartbeat
`timescale 1ns/100ps
`default_nettype none
module mhrw_plc_model
    import mhrw_pkg::*;
(
    // Clock
    input wire logic core_clk,
    // Bench requests
    input wire logic resetReq,
    input wire logic [3:0] abortSel,
    // Module words
    input wire logic [mhrw_pkg::WORD_W-1:0] healthInputWord,
    output logic [mhrw_pkg::WORD_W-1:0] commandOutputWord,
    output logic [mhrw_pkg::WORD_W-1:0] commandControlWord,
    output logic alive
);
    logic [7:0] lastHb_q;
    logic beatSeen_q = 1'b0;
    assign alive = beatSeen_q;
    // Reserved positions always written as zero, so stray bits never hide a refusal
    always_comb begin
        commandOutputWord = {resetReq, 15'h0000};
        commandControlWord = {3'h0, abortSel[3], 3'h0, abortSel[2], 3'h0, abortSel[1],
            3'h0, abortSel[0]};
    end
    // Sticky: any heartbeat change proves the processor ran at least once
    always @(posedge core_clk) begin
        lastHb_q <= healthInputWord[7:0];
        if (healthInputWord[7:0] != lastHb_q) beatSeen_q <= 1'b1;
    end
endmodule : mhrw_plc_model
`default_nettype wire

/* bench/tb_mhrw_core.sv */
// Self-checking bench for the module health and reset word logic
`timescale 1ns/100ps
`default_nettype none
module tb_mhrw_core;
    import mhrw_pkg::*;
    localparam int RETRY = 40;
    localparam int SHORT = 10;
    logic core_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [WORD_W-1:0] commandOutputWord;
    logic [WORD_W-1:0] commandControlWord;
    logic [WORD_W-1:0] healthInputWord;
    logic severeFault = 1'b0, ramRomFault = 1'b0, faultCodeValid = 1'b0;
    logic switchesInvalid = 1'b0, nvStoreInvalid = 1'b0, serialPortsDone = 1'b0;
    logic networkLoaded = 1'b0, linkPulseSeen = 1'b1, moduleReset, alive;
    logic resetReq = 1'b0;
    logic [3:0] abortSel = 4'h0;
    logic [CODE_W-1:0] faultCode = 8'h00;
    logic [7:0] hb;
    int checks = 0;
    int failures = 0;
    int cycles = 0;
    always #20 core_clk = ~core_clk;
    mhrw_core #(.RETRY_CYC(RETRY), .SHORT_CYC(SHORT), .HB_CYC(3)) mhrw_core_inst (
        .core_clk(core_clk), .sys_rst(sys_rst), .commandOutputWord(commandOutputWord),
        .commandControlWord(commandControlWord),
        .healthInputWord(healthInputWord), .severeFault(severeFault),
        .ramRomFault(ramRomFault), .faultCode(faultCode), .faultCodeValid(faultCodeValid),
        .switchesInvalid(switchesInvalid), .nvStoreInvalid(nvStoreInvalid),
        .serialPortsDone(serialPortsDone), .networkLoaded(networkLoaded),
        .linkPulseSeen(linkPulseSeen), .moduleReset(moduleReset));
    mhrw_plc_model mhrw_plc_model_inst (.core_clk(core_clk), .resetReq(resetReq),
        .abortSel(abortSel), .healthInputWord(healthInputWord),
        .commandOutputWord(commandOutputWord), .commandControlWord(commandControlWord),
        .alive(alive));
    task automatic print_verdict();
        $display("checks=%0d failures=%0d", checks, failures);
        if (failures == 0 && checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : print_verdict
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            failures++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    // Index 16 stands for moduleReset
    function automatic logic [15:0] obs(input int b);
        return (b == 16) ? 16'(moduleReset) : 16'(healthInputWord[b]);
    endfunction : obs
    // Setup-fault cases: bad switches, all valid, bad stored settings
    function automatic logic [1:0] cfg_pattern(input int k);
        return (k == 0) ? 2'b10 : ((k == 1) ? 2'b00 : 2'b01);
    endfunction : cfg_pattern
    task automatic expect_hw(input int b, input logic v, input int n);
        for (int i = 0; i < n && obs(b) !== 16'(v); i++) @(negedge core_clk);
        check(obs(b), 16'(v));
    endtask : expect_hw
    task automatic pulse(ref logic s);
        s = 1'b1;
        @(negedge core_clk);
        s = 1'b0;
    endtask : pulse
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 6000) begin
            failures++;
            print_verdict();
        end
    end
    initial begin
        void'($urandom(32'h1f33));
        repeat (10) @(negedge core_clk);
        check(healthInputWord, HEALTH_RESET);
        sys_rst = 1'b0;
        expect_hw(16, 1'b0, 10);
        $display("test startup done");
        pulse(serialPortsDone);
        expect_hw(POS_SER, 1'b0, 4);
        check(obs(POS_NET), 16'h0001);
        pulse(networkLoaded);
        expect_hw(POS_NET, 1'b0, 4);
        hb = healthInputWord[7:0];
        repeat (8) @(negedge core_clk);
        check(16'(healthInputWord[15:8]), 16'h0000);
        check(16'(healthInputWord[7:0] != hb), 16'h0001);
        check(16'(alive), 16'h0001);
        $display("test pending and heartbeat done");
        linkPulseSeen = 1'b0;
        expect_hw(POS_ALT, 1'b1, 4);
        linkPulseSeen = 1'b1;
        expect_hw(POS_ALT, 1'b0, 4);
        $display("test alternate port done");
        faultCode = 8'($urandom);
        pulse(faultCodeValid);
        repeat (3) @(negedge core_clk);
        check(16'(healthInputWord[7:0]), 16'(faultCode));
        $display("test fault code done");
        abortSel = 4'hF;
        repeat (6) @(negedge core_clk);
        check(obs(16), 16'h0000);
        for (int k = 0; k < 4; k++) begin
            abortSel = 4'($urandom_range(0, 14));
            resetReq = 1'b1;
            repeat (6) @(negedge core_clk);
            check(obs(16), 16'h0000);
            resetReq = 1'b0;
            @(negedge core_clk);
        end
        abortSel = 4'hF;
        resetReq = 1'b1;
        expect_hw(16, 1'b1, 4);
        expect_hw(POS_SER, 1'b1, 4);
        expect_hw(16, 1'b0, 10);
        repeat (12) @(negedge core_clk);
        check(obs(16), 16'h0000);
        resetReq = 1'b0;
        @(negedge core_clk);
        for (int k = 0; k < 3; k++) begin
            {switchesInvalid, nvStoreInvalid} = cfg_pattern(k);
            pulse(resetReq);
            expect_hw(16, 1'b1, 4);
            expect_hw(16, 1'b0, 10);
            expect_hw(POS_CFG, |cfg_pattern(k), 4);
        end
        {switchesInvalid, nvStoreInvalid} = 2'b00;
        pulse(serialPortsDone);
        pulse(networkLoaded);
        expect_hw(POS_NET, 1'b0, 4);
        check(obs(POS_SER), 16'h0000);
        $display("test control reset done");
        severeFault = 1'b1;
        expect_hw(POS_FAIL, 1'b1, 4);
        repeat (RETRY / 2) @(negedge core_clk);
        check(obs(16), 16'h0000);
        expect_hw(16, 1'b1, RETRY);
        expect_hw(16, 1'b0, 10);
        expect_hw(16, 1'b1, RETRY + 10);
        severeFault = 1'b0;
        expect_hw(16, 1'b0, 10);
        repeat (4) @(negedge core_clk);
        check(obs(POS_FAIL), 16'h0000);
        $display("test severe fault done");
        ramRomFault = 1'b1;
        expect_hw(POS_DIAG, 1'b1, 4);
        check(obs(POS_FAIL), 16'h0001);
        expect_hw(16, 1'b1, SHORT + 6);
        ramRomFault = 1'b0;
        expect_hw(16, 1'b0, 10);
        $display("test selftest fault done");
        sys_rst = 1'b1;
        repeat (2) @(negedge core_clk);
        check(healthInputWord, HEALTH_RESET);
        check(obs(16), 16'h0001);
        sys_rst = 1'b0;
        expect_hw(16, 1'b0, 10);
        $display("test mid-run reset done");
        print_verdict();
    end
endmodule : tb_mhrw_core
`default_nettype wire
